/* pin_volume_pkg.sv */
package pin_volume_pkg;

   // Register offsets on page 0
   localparam logic [6:0] DC_RESULT_HIGH_OFS   = 7'h68;
   localparam logic [6:0] DC_RESULT_MIDDLE_OFS = 7'h69;
   localparam logic [6:0] DC_RESULT_LOW_OFS    = 7'h6A;
   localparam logic [6:0] VOL_CONV_CTRL_OFS    = 7'h74;
   localparam logic [6:0] VOL_GAIN_READ_OFS    = 7'h75;

   // Reset values
   localparam logic [7:0] DC_RESULT_RESET      = 8'h00;
   localparam logic [7:0] VOL_CONV_CTRL_RESET  = 8'h00;
   localparam logic [7:0] VOL_GAIN_READ_RESET  = 8'h00;

   // Control register fields
   localparam int PIN_CTRL_BIT   = 7;
   localparam int CLK_SRC_BIT    = 6;
   localparam int HYST_MSB       = 5;
   localparam int HYST_LSB       = 4;
   localparam int RSVD_CTRL_BIT  = 3;
   localparam int RATE_MSB       = 2;
   localparam int RATE_LSB       = 0;

   // Gain readout fields
   localparam int GAIN_RSVD_BIT  = 7;
   localparam int GAIN_MSB       = 6;

   // Hysteresis encodings
   localparam logic [1:0] HYST_NONE = 2'h0;
   localparam logic [1:0] HYST_ONE  = 2'h1;
   localparam logic [1:0] HYST_TWO  = 2'h2;

   // Gain code limits
   localparam logic [6:0] GAIN_CODE_MAX      = 7'h7E;
   localparam logic [6:0] GAIN_CODE_RESERVED = 7'h7F;

   // Converter source clock and slowest throughput
   localparam int CONV_SRC_HZ_MCLK  = 12000000;
   localparam int SLOWEST_RATE_MHZ  = 15625;
   // Source edges per conversion at rate code 000
   localparam int CONV_DIV_BASE = (CONV_SRC_HZ_MCLK / SLOWEST_RATE_MHZ) * 1000;

endpackage

/* pin_volume_control_regs.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - The middle DC result byte, bits 15 to 8, reads at offset 0x69 and resets to zero.
// - The low DC result byte, bits 7 to 0, reads at offset 0x6A and resets to zero.
// - The high DC result byte, bits 23 to 16, reads at offset 0x68 just before the middle byte.
// - While result update is disabled the three bytes hold their last value, else they follow.
// - Control bit 0 uses register volume and powers the converter down; 1 follows the pin.
// - The clock-source bit picks the RC oscillator at 0 or the master clock at 1.
// - The hysteresis field gives none, one LSB or two LSBs; software never writes 11.
// - On the RC oscillator the same divide ratios apply, so rates scale with its frequency.
// - Gain readout is a 7-bit code, 0 is 18 dB, each step lowers gain by half a dB.
// - From code 0x5B the gain falls a dB per code to code 0x7E; code 0x7F never appears.
module pin_volume_control_regs
   import pin_volume_pkg::*;
#(
   parameter int DIV_BASE = CONV_DIV_BASE
) (
   input  wire logic        clk_sys,          // System clock, 25 MHz
   input  wire logic        resetn,           // Async reset, active low
   input  wire logic [6:0]  reg_addr,         // Register offset, page 0
   input  wire logic        reg_wr,           // Register write strobe
   input  wire logic        reg_rd,           // Register read strobe
   input  wire logic [7:0]  reg_wdata,        // Register write data
   output logic      [7:0]  reg_rdata,        // Register read data
   input  wire logic [23:0] dc_result,        // DC measurement filter output
   input  wire logic        dc_result_valid,  // New DC result pulse
   input  wire logic        dc_update_off,    // Result update disabled
   input  wire logic        mclk_pin,         // Master clock pin
   input  wire logic        rc_osc_pin,       // Internal RC oscillator
   input  wire logic [6:0]  vol_sar_code,     // Converter result from analog
   output logic             vol_sar_pd,       // Converter power down
   output logic             vol_sar_start,    // Sample pulse to converter
   input  wire logic [6:0]  reg_volume_code,  // Volume from control register
   output logic      [6:0]  playback_gain     // Applied playback gain code
);

   localparam int CNT_W = $clog2(DIV_BASE + 1);

   logic [7:0]       dc_high_reg;
   logic [7:0]       dc_mid_reg;
   logic [7:0]       dc_low_reg;
   logic [7:0]       ctrl_reg;
   logic             gain_rsvd_reg;
   logic [6:0]       gain_reg;
   logic [7:0]       rdata_reg;
   logic             mclk_sync;
   logic             rc_sync;
   logic             mclk_hist_reg;
   logic             rc_hist_reg;
   logic [2:0]       edge_arm_reg;
   logic [1:0]       sar_sync_en_reg;
   logic [6:0]       sar_code_sync;
   logic [6:0]       sar_prev_reg;
   logic             gain_pend_reg;
   logic             code_steady;
   logic [7:0]       rdata_next;
   logic [CNT_W-1:0] div_cnt_reg;
   logic [6:0]       gain_next;
   logic [CNT_W-1:0] period;
   logic             pin_ctrl;
   logic             src_tick;
   logic             conv_done;
   logic [6:0]       diff;
   logic [1:0]       hyst;
   logic             gain_move;
   logic [6:0]       sar_clamped;

   assign pin_ctrl = ctrl_reg[PIN_CTRL_BIT];

   // DC result hold
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dc_high_reg <= DC_RESULT_RESET;
         dc_mid_reg  <= DC_RESULT_RESET;
         dc_low_reg  <= DC_RESULT_RESET;
      end else if (dc_result_valid && !dc_update_off) begin
         dc_high_reg <= dc_result[23:16];
         dc_mid_reg  <= dc_result[15:8];
         dc_low_reg  <= dc_result[7:0];
      end
   end

   // Control register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= VOL_CONV_CTRL_RESET;
      end else if (reg_wr && (reg_addr == VOL_CONV_CTRL_OFS)) begin
         ctrl_reg <= reg_wdata;
      end
   end

   // Readout register top bit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gain_rsvd_reg <= VOL_GAIN_READ_RESET[GAIN_RSVD_BIT];
      end else if (reg_wr && (reg_addr == VOL_GAIN_READ_OFS)) begin
         gain_rsvd_reg <= reg_wdata[GAIN_RSVD_BIT];
      end
   end

   // Read data select
   always_comb begin
      if (reg_addr == DC_RESULT_HIGH_OFS) begin
         rdata_next = dc_high_reg;
      end else if (reg_addr == DC_RESULT_MIDDLE_OFS) begin
         rdata_next = dc_mid_reg;
      end else if (reg_addr == DC_RESULT_LOW_OFS) begin
         rdata_next = dc_low_reg;
      end else if (reg_addr == VOL_CONV_CTRL_OFS) begin
         rdata_next = ctrl_reg;
      end else if (reg_addr == VOL_GAIN_READ_OFS) begin
         rdata_next = {gain_rsvd_reg, gain_reg};
      end else begin
         rdata_next = 8'h00;
      end
   end

   // Read data, held until the next read
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // Source clock synchronisers
   two_stage_sync #(
      .WIDTH(1)
   ) mclk_sync_inst (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .async_in (mclk_pin),
      .sync_out (mclk_sync)
   );

   two_stage_sync #(
      .WIDTH(1)
   ) rc_sync_inst (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .async_in (rc_osc_pin),
      .sync_out (rc_sync)
   );

   // Edge history, armed once the synchronisers hold real samples
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mclk_hist_reg <= 1'h0;
         rc_hist_reg   <= 1'h0;
         edge_arm_reg  <= 3'h0;
      end else begin
         mclk_hist_reg <= mclk_sync;
         rc_hist_reg   <= rc_sync;
         edge_arm_reg  <= {edge_arm_reg[1:0], 1'h1};
      end
   end

   always_comb begin
      if (ctrl_reg[CLK_SRC_BIT]) begin
         src_tick = edge_arm_reg[2] & mclk_sync & ~mclk_hist_reg;
      end else begin
         src_tick = edge_arm_reg[2] & rc_sync & ~rc_hist_reg;
      end
   end

   // same ratio on the RC oscillator
   assign period = CNT_W'(DIV_BASE >> ctrl_reg[RATE_MSB:RATE_LSB]);
   assign conv_done = pin_ctrl && src_tick && (div_cnt_reg >= period - CNT_W'(1));

   // Conversion divider
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_cnt_reg <= '0;
      end else if (!pin_ctrl) begin
         div_cnt_reg <= '0;
      end else if (conv_done) begin
         div_cnt_reg <= '0;
      end else if (src_tick) begin
         div_cnt_reg <= div_cnt_reg + CNT_W'(1);
      end
   end

   assign vol_sar_pd    = ~pin_ctrl;
   assign vol_sar_start = conv_done;

   // Converter result word, two stages, then a steadiness check
   two_stage_sync #(
      .WIDTH(7)
   ) sar_sync_inst (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .async_in (vol_sar_code),
      .sync_out (sar_code_sync)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sar_sync_en_reg <= 2'h0;
         sar_prev_reg    <= 7'h00;
      end else begin
         sar_sync_en_reg <= {sar_sync_en_reg[0], conv_done};
         sar_prev_reg    <= sar_code_sync;
      end
   end

   // A word caught while changing waits for a steady cycle
   assign code_steady = (sar_code_sync == sar_prev_reg);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gain_pend_reg <= 1'h0;
      end else if (!pin_ctrl) begin
         gain_pend_reg <= 1'h0;
      end else if (sar_sync_en_reg[1] && !code_steady) begin
         gain_pend_reg <= 1'h1;
      end else if (code_steady) begin
         gain_pend_reg <= 1'h0;
      end
   end

   assign sar_clamped = (sar_code_sync == GAIN_CODE_RESERVED) ? GAIN_CODE_MAX : sar_code_sync;

   always_comb begin
      if (sar_clamped > gain_reg) begin
         diff = sar_clamped - gain_reg;
      end else begin
         diff = gain_reg - sar_clamped;
      end
      case (ctrl_reg[HYST_MSB:HYST_LSB])
         HYST_NONE: hyst = 2'h0;
         HYST_ONE:  hyst = 2'h1;
         HYST_TWO:  hyst = 2'h2;
         default:   hyst = 2'h2;
      endcase
      gain_move = diff > {5'h00, hyst};
      gain_next = gain_move ? sar_clamped : gain_reg;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gain_reg <= VOL_GAIN_READ_RESET[GAIN_MSB:0];
      end else if (pin_ctrl && (sar_sync_en_reg[1] || gain_pend_reg) && code_steady) begin
         gain_reg <= gain_next;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         playback_gain <= VOL_GAIN_READ_RESET[GAIN_MSB:0];
      end else if (pin_ctrl) begin
         playback_gain <= gain_reg;
      end else begin
         playback_gain <= reg_volume_code;
      end
   end

endmodule

module two_stage_sync
   import pin_volume_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,   // System clock
   input  wire logic             resetn,    // Async reset, active low
   input  wire logic [WIDTH-1:0] async_in,  // Signal from another domain
   output logic      [WIDTH-1:0] sync_out   // Second stage, safe to read
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // Only the second stage leaves this module
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

/* pin_volume_control_regs_asserts.sv */
`timescale 1ns/1ns
module pin_volume_control_regs_asserts
   import pin_volume_pkg::*;
(
   input wire logic        clk_sys,         // Clock
   input wire logic        resetn,          // Reset
   input wire logic [6:0]  reg_addr,        // Offset
   input wire logic        reg_wr,          // Write
   input wire logic        reg_rd,          // Read
   input wire logic [7:0]  reg_wdata,       // Write data
   input wire logic [7:0]  reg_rdata,       // Read data
   input wire logic [23:0] dc_result,       // DC result
   input wire logic        dc_result_valid, // DC valid
   input wire logic        dc_update_off,   // DC freeze
   input wire logic [6:0]  reg_volume_code, // Register volume
   input wire logic        vol_sar_pd,      // Power down
   input wire logic        vol_sar_start,   // Sample pulse
   input wire logic [6:0]  playback_gain    // Applied gain
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Result taken, then read next cycle
   sequence s_dc_take;
      dc_result_valid && !dc_update_off ##1 reg_rd;
   endsequence
   property p_dc_high;
      s_dc_take ##0 reg_addr == DC_RESULT_HIGH_OFS |=> reg_rdata == $past(dc_result[23:16], 2);
   endproperty
   a_dc_high: assert property (p_dc_high) else $error("high byte wrong");
   property p_dc_mid;
      s_dc_take ##0 reg_addr == DC_RESULT_MIDDLE_OFS |=> reg_rdata == $past(dc_result[15:8], 2);
   endproperty
   a_dc_mid: assert property (p_dc_mid) else $error("middle byte wrong");
   property p_dc_low;
      s_dc_take ##0 reg_addr == DC_RESULT_LOW_OFS |=> reg_rdata == $past(dc_result[7:0], 2);
   endproperty
   a_dc_low: assert property (p_dc_low) else $error("low byte wrong");
   property p_pd_wr;
      reg_wr && reg_addr == VOL_CONV_CTRL_OFS |=> vol_sar_pd == !$past(reg_wdata[PIN_CTRL_BIT]);
   endproperty
   a_pd_wr: assert property (p_pd_wr) else $error("power down wrong");
   property p_pd_idle;
      vol_sar_pd |-> !vol_sar_start;
   endproperty
   a_pd_idle: assert property (p_pd_idle) else $error("start while down");
   property p_reg_gain;
      vol_sar_pd |=> playback_gain == $past(reg_volume_code);
   endproperty
   a_reg_gain: assert property (p_reg_gain) else $error("register gain wrong");
   property p_start_pulse;
      vol_sar_start |=> !vol_sar_start [*2];
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_gain_rsvd;
      !vol_sar_pd && !$past(vol_sar_pd) |-> playback_gain != GAIN_CODE_RESERVED;
   endproperty
   a_gain_rsvd: assert property (p_gain_rsvd) else $error("reserved gain");
endmodule

/* pin_volume_control_regs_bench.sv */
`timescale 1ns/1ns
module pin_volume_control_regs_bench;
   import pin_volume_pkg::*;
   logic        clk_sys, resetn, reg_wr, reg_rd, dc_result_valid, dc_update_off;
   logic        mclk_pin, rc_osc_pin, mrun, rrun, vol_sar_pd, vol_sar_start;
   logic [6:0]  reg_addr, vol_sar_code, reg_volume_code, playback_gain;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [23:0] dc_result;
   int          err_count, comparisons, c;
   pin_volume_control_regs #(
      .DIV_BASE(128)
   ) dut (
      .clk_sys         (clk_sys),
      .resetn          (resetn),
      .reg_addr        (reg_addr),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_wdata       (reg_wdata),
      .reg_rdata       (reg_rdata),
      .dc_result       (dc_result),
      .dc_result_valid (dc_result_valid),
      .dc_update_off   (dc_update_off),
      .mclk_pin        (mclk_pin),
      .rc_osc_pin      (rc_osc_pin),
      .vol_sar_code    (vol_sar_code),
      .vol_sar_pd      (vol_sar_pd),
      .vol_sar_start   (vol_sar_start),
      .reg_volume_code (reg_volume_code),
      .playback_gain   (playback_gain)
   );
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Pin clocks kept off the clk_sys edges
   initial begin
      #10;
      forever #60 if (mrun) mclk_pin = ~mclk_pin;
   end
   initial begin
      #10;
      forever #100 if (rrun) rc_osc_pin = ~rc_osc_pin;
   end
   task chk(string n, logic [7:0] e, logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(logic [6:0] a, logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task rdc(string n, logic [6:0] a, logic [7:0] e);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk(n, e, reg_rdata);
   endtask
   task cnt(int n);
      c = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (vol_sar_start === 1'b1) c++;
      end
   endtask
   // Wait for a conversion, then let the gain land
   task wst;
      int i;
      for (i = 0; i < 3000 && vol_sar_start !== 1'b1; i++) @(negedge clk_sys);
      if (i == 3000) begin
         err_count++;
         $display("Error start expected 1 seen 0");
         end_of_test;
      end else begin
         repeat (4) @(negedge clk_sys);
      end
   endtask
   task t_dc;
      for (int a = 'h68; a < 'h6B; a++) rdc("dc_reset", 7'(a), DC_RESULT_RESET);
      dc_result = 24'hA5C33C;
      dc_result_valid = 1'b1;
      rdc("dc_high", DC_RESULT_HIGH_OFS, 8'hA5);
      rdc("dc_mid", DC_RESULT_MIDDLE_OFS, 8'hC3);
      wr(DC_RESULT_LOW_OFS, 8'hFF);
      rdc("dc_low", DC_RESULT_LOW_OFS, 8'h3C);
      dc_update_off = 1'b1;
      dc_result = 24'h123456;
      rdc("dc_frozen", DC_RESULT_MIDDLE_OFS, 8'hC3);
      dc_result_valid = 1'b0;
      dc_update_off = 1'b0;
      $display("t_dc done");
   endtask
   task t_ctrl;
      rdc("ctrl_reset", VOL_CONV_CTRL_OFS, VOL_CONV_CTRL_RESET);
      rdc("gain_reset", VOL_GAIN_READ_OFS, VOL_GAIN_READ_RESET);
      for (int h = 0; h < 3; h++) begin
         wr(VOL_CONV_CTRL_OFS, {2'h0, 2'(h), 4'h5});
         rdc("hyst", VOL_CONV_CTRL_OFS, {2'h0, 2'(h), 4'h5});
      end
      rdc("unmapped", 7'h70, 8'h00);
      chk("reg_gain", 8'h33, {1'b0, playback_gain});
      $display("t_ctrl done");
   endtask
   task t_pin;
      wr(VOL_CONV_CTRL_OFS, 8'hC4);
      chk("pd", 8'h00, {7'h0, vol_sar_pd});
      wst;
      wst;
      rdc("gain", VOL_GAIN_READ_OFS, 8'h24);
      chk("play", 8'h24, {1'b0, playback_gain});
      vol_sar_code = 7'h7F;
      wst;
      rdc("gain_max", VOL_GAIN_READ_OFS, 8'h7E);
      wr(VOL_CONV_CTRL_OFS, 8'hD4);
      vol_sar_code = 7'h7D;
      wst;
      rdc("hyst_hold", VOL_GAIN_READ_OFS, 8'h7E);
      vol_sar_code = 7'h7C;
      wst;
      rdc("hyst_move", VOL_GAIN_READ_OFS, 8'h7C);
      wr(VOL_CONV_CTRL_OFS, 8'hE4);
      vol_sar_code = 7'h7A;
      wst;
      rdc("hyst2_hold", VOL_GAIN_READ_OFS, 8'h7C);
      vol_sar_code = 7'h79;
      wst;
      rdc("hyst2_move", VOL_GAIN_READ_OFS, 8'h79);
      for (int r = 3; r < 6; r++) begin
         wr(VOL_CONV_CTRL_OFS, {5'h18, 3'(r)});
         wst;
         cnt(240);
         chk("rate", 8'h01, {7'h0, c >= (5 << (r - 3)) - 1 && c <= (5 << (r - 3)) + 1});
      end
      $display("t_pin done");
   endtask
   task t_clk;
      mrun = 1'b0;
      rrun = 1'b1;
      wr(VOL_CONV_CTRL_OFS, 8'hC4);
      cnt(20);
      cnt(200);
      chk("mclk_stopped", 8'h00, 8'(c));
      wr(VOL_CONV_CTRL_OFS, 8'h84);
      wst;
      wr(VOL_CONV_CTRL_OFS, 8'h04);
      reg_volume_code = 7'h11;
      repeat (2) @(negedge clk_sys);
      chk("reg_gain", 8'h11, {1'b0, playback_gain});
      $display("t_clk done");
   endtask
   task end_of_test;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {resetn, reg_wr, reg_rd, dc_result_valid, dc_update_off, rrun} = '0;
      {mclk_pin, rc_osc_pin, mrun} = 3'h1;
      {reg_addr, reg_wdata, dc_result} = '0;
      vol_sar_code = 7'h24;
      reg_volume_code = 7'h33;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      t_dc;
      t_ctrl;
      t_pin;
      t_clk;
      end_of_test;
   end
endmodule
bind pin_volume_control_regs pin_volume_control_regs_asserts u_chk (
   .clk_sys         (clk_sys),
   .resetn          (resetn),
   .reg_addr        (reg_addr),
   .reg_wr          (reg_wr),
   .reg_rd          (reg_rd),
   .reg_wdata       (reg_wdata),
   .reg_rdata       (reg_rdata),
   .dc_result       (dc_result),
   .dc_result_valid (dc_result_valid),
   .dc_update_off   (dc_update_off),
   .reg_volume_code (reg_volume_code),
   .vol_sar_pd      (vol_sar_pd),
   .vol_sar_start   (vol_sar_start),
   .playback_gain   (playback_gain)
);
